// >>> src/sdc_checker.sv
/*
 Segment descriptor checker. Software loads the two descriptor words, the
 offset and the control word, then writes the start command; two cycles later
 the status, decoded base and limit, gate target and exception appear.
 Assumes the core fetches descriptors and writes back the accessed byte.
*/
`timescale 1ns/1ps
module sdc_checker
    import sdc_pkg::*;
(
    input  wire logic                  CLK_I,
    input  wire logic                  RESET_I,
    input  wire logic [5:0]            ADDR_I,
    input  wire logic [31:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic      [31:0]           RDATA_O,
    output logic                       DONE_O,
    output logic                       EXC_VALID_O,
    output logic      [7:0]            EXC_VECTOR_O,
    output logic                       IF_CLEAR_O,
    output logic                       ACC_WB_O
);
`include "sdc_regs.svh"

    sdc_regs_t r_r;
    sdc_regs_t r_nxt;
    sdc_dec_if dif ();

    sdc_decode u_decode (
        .d (dif)
    );

    assign dif.lo = r_r.desc_lo;
    assign dif.hi = r_r.desc_hi;

    sdc_kind_t   kind;
    logic        ti_glob;
    logic        priv_chg;
    logic [7:0]  tgt_acc;
    logic        is_code;
    logic        is_data;
    logic        readable;
    logic        writable;
    logic        exp_down;
    logic        conform;
    logic [31:0] eff_limit;
    logic [31:0] upper;
    logic        in_limit;
    logic        is_ldt;
    logic        is_tss;
    logic        tss_busy;
    logic        tss_native;
    logic        is_gate;
    logic        g_call;
    logic        g_task;
    logic        g_int;
    logic        g_trap;
    logic        g_native;
    logic        tgt_code;
    logic        tgt_tss;
    logic        fault_np;
    logic        fault_gp;
    logic        ok;
    logic [7:0]  acc_new;
    logic [7:0]  wc_bytes;

    always_comb
    begin
        kind     = sdc_kind_t'(r_r.ctrl[`SDC_CTRL_KIND_LSB +: 3]);
        ti_glob  = r_r.ctrl[`SDC_CTRL_TI_GLOB];
        priv_chg = r_r.ctrl[`SDC_CTRL_PRIV_CHG];
        tgt_acc  = r_r.ctrl[`SDC_CTRL_TGT_LSB +: 8];

        is_code  = dif.cls & dif.typ[3];
        is_data  = dif.cls & ~dif.typ[3];
        readable = is_code & dif.typ[1];
        writable = is_data & dif.typ[1];
        exp_down = is_data & dif.typ[2];
        conform  = is_code & dif.typ[2];

        // Page units fill the low twelve bits, whether or not paging is on
        eff_limit = dif.gran ? {dif.limit, 12'hFFF} : {12'h000, dif.limit};
        upper     = dif.big ? `SDC_BIG_UPPER : `SDC_SMALL_UPPER;
        if (exp_down)
        begin
            in_limit = (r_r.offset > eff_limit) && (r_r.offset <= upper);
        end
        else
        begin
            in_limit = (r_r.offset <= eff_limit);
        end

        // System types only exist with the class flag clear
        is_ldt     = ~dif.cls && (dif.typ == 4'h2);
        is_tss     = ~dif.cls && (dif.typ[2:0] == 3'h1 || dif.typ[2:0] == 3'h3);
        tss_busy   = dif.typ[1];
        tss_native = dif.typ[3];
        g_call     = ~dif.cls && (dif.typ == 4'h4 || dif.typ == 4'hC);
        g_task     = ~dif.cls && (dif.typ == 4'h5);
        g_int      = ~dif.cls && (dif.typ == 4'h6 || dif.typ == 4'hE);
        g_trap     = ~dif.cls && (dif.typ == 4'h7 || dif.typ == 4'hF);
        g_native   = dif.typ[3];
        is_gate    = g_call | g_task | g_int | g_trap;

        // Target descriptor access byte, supplied with the gate check
        tgt_code = tgt_acc[`SDC_ACC_S] & tgt_acc[3];
        tgt_tss  = ~tgt_acc[`SDC_ACC_S] && (tgt_acc[2:0] == 3'h1 || tgt_acc[2:0] == 3'h3);

        fault_np = 1'b0;
        fault_gp = 1'b0;
        if (!dif.present)
        begin
            fault_np = 1'b1;
        end
        else if (kind == SDC_K_GATE)
        begin
            if (!is_gate)
            begin
                fault_gp = 1'b1;
            end
            else if (g_task)
            begin
                fault_gp = ~tgt_tss;
            end
            else
            begin
                fault_gp = ~tgt_code;
            end
        end
        else if (kind == SDC_K_SYS)
        begin
            // Privilege is not looked at for a local table descriptor
            fault_gp = ~(is_tss | (is_ldt & ti_glob));
        end
        else if (!dif.cls)
        begin
            fault_gp = 1'b1;
        end
        else
        begin
            case (kind)
                SDC_K_READ:  fault_gp = (is_code & ~readable) | ~in_limit;
                SDC_K_WRITE: fault_gp = is_code | ~writable | ~in_limit;
                SDC_K_EXEC:  fault_gp = ~is_code | ~in_limit;
                SDC_K_STACK: fault_gp = ~writable | ~in_limit;
                default:     fault_gp = 1'b1;
            endcase
        end
        ok = ~fault_np & ~fault_gp;

        acc_new    = r_r.desc_hi[15:8];
        acc_new[0] = acc_new[0] | dif.cls;

        // Bytes to copy: words of two or four bytes, only on a privilege change
        if (g_call && priv_chg)
        begin
            wc_bytes = g_native ? {1'b0, dif.wcount, 2'b00} : {2'b00, dif.wcount, 1'b0};
        end
        else
        begin
            wc_bytes = 8'h00;
        end
    end

    always_comb
    begin
        r_nxt           = r_r;
        r_nxt.done      = 1'b0;
        r_nxt.exc_valid = 1'b0;
        r_nxt.if_clear  = 1'b0;
        r_nxt.acc_wb    = 1'b0;
        r_nxt.rdata     = 32'h0000_0000;

        if (WR_I)
        begin
            if (ADDR_I == `SDC_A_DESC_LO)
            begin
                r_nxt.desc_lo = WDATA_I;
            end
            else if (ADDR_I == `SDC_A_DESC_HI)
            begin
                r_nxt.desc_hi = WDATA_I;
            end
            else if (ADDR_I == `SDC_A_OFFSET)
            begin
                r_nxt.offset = WDATA_I;
            end
            else if (ADDR_I == `SDC_A_CTRL)
            begin
                r_nxt.ctrl = WDATA_I;
            end
            else if (ADDR_I == `SDC_A_CMD && WDATA_I[`SDC_CMD_GO] && r_r.state == SDC_IDLE)
            begin
                r_nxt.state     = SDC_CHECK;
                r_nxt.status[0] = 1'b1;
            end
        end

        if (RD_I)
        begin
            if (ADDR_I == `SDC_A_DESC_LO)
            begin
                r_nxt.rdata = r_r.desc_lo;
            end
            else if (ADDR_I == `SDC_A_DESC_HI)
            begin
                r_nxt.rdata = r_r.desc_hi;
            end
            else if (ADDR_I == `SDC_A_OFFSET)
            begin
                r_nxt.rdata = r_r.offset;
            end
            else if (ADDR_I == `SDC_A_CTRL)
            begin
                r_nxt.rdata = r_r.ctrl;
            end
            else if (ADDR_I == `SDC_A_STATUS)
            begin
                r_nxt.rdata = {16'h0000, r_r.status};
            end
            else if (ADDR_I == `SDC_A_BASE)
            begin
                r_nxt.rdata = r_r.base;
            end
            else if (ADDR_I == `SDC_A_LIMIT)
            begin
                r_nxt.rdata = r_r.limit;
            end
            else if (ADDR_I == `SDC_A_GATE)
            begin
                r_nxt.rdata = r_r.gate;
            end
            else if (ADDR_I == `SDC_A_GOFF)
            begin
                r_nxt.rdata = r_r.goff;
            end
            else if (ADDR_I == `SDC_A_PARAM)
            begin
                r_nxt.rdata = r_r.param;
            end
        end

        case (r_r.state)
            SDC_IDLE:
            begin
                r_nxt.state = r_nxt.state;
            end
            SDC_CHECK:
            begin
                // Descriptor registers written in this cycle are seen by the next check only
                r_nxt.state      = SDC_IDLE;
                r_nxt.done       = 1'b1;
                r_nxt.status     = {tss_native, tss_busy, conform, exp_down, is_gate, is_tss,
                                    is_ldt, dif.legacy, dif.big, dif.gran, 1'b0,
                                    fault_gp, fault_np, ok, 1'b1, 1'b0};
                r_nxt.base       = dif.base;
                r_nxt.limit      = eff_limit;
                r_nxt.gate       = {dif.sel, acc_new, 3'h0, dif.wcount};
                // Task gates carry no entry point, so none is reported
                r_nxt.goff       = (is_gate && !g_task) ? (g_native ? dif.goff : {16'h0000, dif.goff[15:0]})
                                                        : 32'h0000_0000;
                r_nxt.param      = {24'h00_0000, wc_bytes};
                r_nxt.exc_valid  = fault_np | fault_gp;
                r_nxt.exc_vec    = fault_np ? `SDC_EXC_NP : (fault_gp ? `SDC_EXC_GP : 8'h00);
                r_nxt.if_clear   = ok & (kind == SDC_K_GATE) & g_int;
                // Write-back only when the flag was still clear
                r_nxt.acc_wb     = dif.present & dif.cls & ~r_r.desc_hi[8] & (kind != SDC_K_GATE);
            end
            default:
            begin
                r_nxt.state = SDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            r_r       <= '0;
            r_r.state <= SDC_IDLE;
            r_r.ctrl  <= `SDC_CTRL_RESET;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // Every output is a bit of the state record, so the pins never glitch
    assign RDATA_O      = r_r.rdata;
    assign DONE_O       = r_r.done;
    assign EXC_VALID_O  = r_r.exc_valid;
    assign EXC_VECTOR_O = r_r.exc_vec;
    assign IF_CLEAR_O   = r_r.if_clear;
    assign ACC_WB_O     = r_r.acc_wb;

endmodule : sdc_checker

// >>> src/sdc_regs.svh
/*
 Register offsets, field positions, reset values and figures for the segment
 descriptor checker. Assumes a plain address/strobe register port, byte
 addresses of aligned 32-bit words, and the descriptor words fetched by the host.
*/
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_ADDR_W        6
`define SDC_A_DESC_LO     6'h00
`define SDC_A_DESC_HI     6'h04
`define SDC_A_OFFSET      6'h08
`define SDC_A_CTRL        6'h0C
`define SDC_A_CMD         6'h10
`define SDC_A_STATUS      6'h14
`define SDC_A_BASE        6'h18
`define SDC_A_LIMIT       6'h1C
`define SDC_A_GATE        6'h20
`define SDC_A_GOFF        6'h24
`define SDC_A_PARAM       6'h28

`define SDC_CTRL_KIND_LSB 0
`define SDC_CTRL_TI_GLOB  3
`define SDC_CTRL_PRIV_CHG 4
`define SDC_CTRL_TGT_LSB  8
`define SDC_CMD_GO        0
`define SDC_CTRL_RESET    32'h0000_0000

`define SDC_ACC_P         7
`define SDC_ACC_DPL_LSB   5
`define SDC_ACC_S         4
`define SDC_PAGE_BITS     12
`define SDC_BIG_UPPER     32'h0FFF_FFFF
`define SDC_SMALL_UPPER   32'h0000_FFFF
`define SDC_EXC_NP        8'h0B
`define SDC_EXC_GP        8'h0D

`endif

// >>> src/sdc_pkg.sv
/*
 Types of the segment descriptor checker. Assumes sdc_regs.svh for the numbers.
*/
package sdc_pkg;

    typedef enum logic [1:0] {SDC_IDLE = 2'b01, SDC_CHECK = 2'b10} sdc_state_t;

    typedef enum logic [2:0] {
        SDC_K_READ  = 3'h0,
        SDC_K_WRITE = 3'h1,
        SDC_K_EXEC  = 3'h2,
        SDC_K_STACK = 3'h3,
        SDC_K_GATE  = 3'h4,
        SDC_K_SYS   = 3'h5
    } sdc_kind_t;

    typedef struct packed {
        sdc_state_t  state;
        logic [31:0] desc_lo;
        logic [31:0] desc_hi;
        logic [31:0] offset;
        logic [31:0] ctrl;
        logic [15:0] status;
        logic [31:0] base;
        logic [31:0] limit;
        logic [31:0] gate;
        logic [31:0] goff;
        logic [31:0] param;
        logic [31:0] rdata;
        logic        done;
        logic        exc_valid;
        logic [7:0]  exc_vec;
        logic        if_clear;
        logic        acc_wb;
    } sdc_regs_t;

endpackage : sdc_pkg

// >>> src/sdc_dec_if.sv
/*
 Carrier between the checker and its field decoder: the two descriptor words
 in, the raw fields out. Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
interface sdc_dec_if;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        present;
    logic [1:0]  descriptor_privilege_field;
    logic        cls;
    logic [3:0]  typ;
    logic        gran;
    logic        big;
    logic        legacy;
    logic [31:0] base;
    logic [19:0] limit;
    logic [15:0] sel;
    logic [31:0] goff;
    logic [4:0]  wcount;

    modport dec (input lo, hi, output present, descriptor_privilege_field, cls, typ, gran, big, legacy, base, limit, sel, goff, wcount);
    modport chk (output lo, hi, input present, descriptor_privilege_field, cls, typ, gran, big, legacy, base, limit, sel, goff, wcount);
endinterface : sdc_dec_if

// >>> src/sdc_decode.sv
/*
 Splits a descriptor into its fields. Purely combinational; assumes the caller
 presents both words at once and decides the meaning of each type.
*/
`timescale 1ns/1ps
module sdc_decode
    import sdc_pkg::*;
(
    sdc_dec_if.dec d
);
`include "sdc_regs.svh"

    logic [7:0] acc;

    // Access byte layout
    assign acc       = d.hi[15:8];
    assign d.present = acc[`SDC_ACC_P];
    assign d.descriptor_privilege_field     = acc[`SDC_ACC_DPL_LSB +: 2];
    assign d.cls     = acc[`SDC_ACC_S];
    assign d.typ     = acc[3:0];
    // A legacy descriptor has no granularity or size bits to honour
    assign d.legacy  = (d.hi[31:16] == 16'h0000);
    assign d.gran    = d.hi[23] & ~d.legacy;
    assign d.big     = d.hi[22]; // Default size for code, stack size for data
    // Native: 32-bit base, 20-bit limit; legacy: 24-bit base, 16-bit limit
    assign d.base    = d.legacy ? {8'h00, d.hi[7:0], d.lo[31:16]} : {d.hi[31:24], d.hi[7:0], d.lo[31:16]};
    assign d.limit   = d.legacy ? {4'h0, d.lo[15:0]} : {d.hi[19:16], d.lo[15:0]};
    assign d.sel     = d.lo[31:16];
    assign d.goff    = {d.hi[31:16], d.lo[15:0]};
    assign d.wcount  = d.hi[4:0];

endmodule : sdc_decode

// >>> tb/sdc_checker_properties.sv
/*
 Port-level checks of the segment descriptor checker.
 Assumes one clock, synchronous active-high reset and the register map of sdc_regs.svh.
*/
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_checker_properties
    import sdc_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    input wire logic [5:0]  ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        DONE_O,
    input wire logic        EXC_VALID_O,
    input wire logic [7:0]  EXC_VECTOR_O,
    input wire logic        IF_CLEAR_O,
    input wire logic        ACC_WB_O
);
    logic        take;
    logic        busy_r;
    logic [31:0] hi_r;
    logic [31:0] shi_r;
    logic [2:0]  kind_r;
    logic [2:0]  skind_r;

    // A start during the check cycle is ignored, so it must not count as a start
    assign take = WR_I && ADDR_I == `SDC_A_CMD && WDATA_I[`SDC_CMD_GO] && !busy_r;

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            busy_r  <= 1'b0;
            hi_r    <= 32'h0;
            shi_r   <= 32'h0;
            kind_r  <= 3'h0;
            skind_r <= 3'h0;
        end
        else
        begin
            busy_r <= take;
            if (WR_I && ADDR_I == `SDC_A_DESC_HI) hi_r <= WDATA_I;
            if (WR_I && ADDR_I == `SDC_A_CTRL) kind_r <= WDATA_I[2:0];
            if (take) shi_r <= hi_r;
            if (take) skind_r <= kind_r;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    chk_done_timing: assert property (take |-> ##2 DONE_O) else $error("check did not finish in time");
    chk_done_cause: assert property (DONE_O |-> $past(take, 2)) else $error("finish without a start");
    chk_pulse_len: assert property (DONE_O |=> !DONE_O && !EXC_VALID_O && !IF_CLEAR_O && !ACC_WB_O)
        else $error("result pulse longer than one cycle");
    chk_exc_vector: assert property (EXC_VALID_O |-> DONE_O && (EXC_VECTOR_O == `SDC_EXC_NP
        || EXC_VECTOR_O == `SDC_EXC_GP)) else $error("bad exception vector");
    chk_not_present: assert property (DONE_O && !shi_r[15] |-> EXC_VALID_O
        && EXC_VECTOR_O == `SDC_EXC_NP) else $error("absent descriptor not refused");
    chk_code_write: assert property (DONE_O && shi_r[15] && shi_r[12:11] == 2'b11
        && skind_r == SDC_K_WRITE |-> EXC_VALID_O && EXC_VECTOR_O == `SDC_EXC_GP) else $error("code write passed");
    chk_stack_ro: assert property (DONE_O && shi_r[15] && shi_r[12:11] == 2'b10 && !shi_r[9]
        && skind_r == SDC_K_STACK |-> EXC_VALID_O && EXC_VECTOR_O == `SDC_EXC_GP) else $error("read-only stack passed");
    chk_int_gate: assert property (IF_CLEAR_O |-> DONE_O && !EXC_VALID_O && skind_r == SDC_K_GATE
        && !shi_r[12] && shi_r[10:8] == 3'b110) else $error("interrupt flag cleared wrongly");
    chk_acc_flag: assert property (ACC_WB_O |-> DONE_O && shi_r[15] && shi_r[12] && !shi_r[8]
        && skind_r != SDC_K_GATE) else $error("accessed write-back wrongly raised");
    chk_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0) else $error("read data outside its cycle");

    cov_pass: cover property (DONE_O && !EXC_VALID_O);
    cov_absent: cover property (EXC_VALID_O && EXC_VECTOR_O == `SDC_EXC_NP);
    cov_int_gate: cover property (IF_CLEAR_O);
endmodule : sdc_checker_properties

bind sdc_checker sdc_checker_properties u_props (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DONE_O(DONE_O), .EXC_VALID_O(EXC_VALID_O),
    .EXC_VECTOR_O(EXC_VECTOR_O), .IF_CLEAR_O(IF_CLEAR_O), .ACC_WB_O(ACC_WB_O));

// >>> tb/sdc_desc_mem.sv
/*
 Descriptor table memory: eight 64-bit entries, read combinationally.
 Assumes the bench fills entries through put and the core's write-back pulse.
*/
`timescale 1ns/1ps
module sdc_desc_mem
(
    input  wire logic        clk_i,
    input  wire logic [2:0]  idx_i,
    input  wire logic        wb_i,
    output logic      [31:0] lo_o,
    output logic      [31:0] hi_o
);
    logic [63:0] tab [8];

    assign lo_o = tab[idx_i][31:0];
    assign hi_o = tab[idx_i][63:32];

    task automatic put(input logic [2:0] i, input logic [63:0] d);
        tab[i] = d;
    endtask : put

    // Only the accessed bit changes; the rest of the access byte is not written at all
    always @(posedge clk_i)
        if (wb_i) tab[idx_i][40] <= 1'b1;
endmodule : sdc_desc_mem

// >>> tb/tb.sv
/*
 Self-checking bench of the descriptor checker with a descriptor memory model.
 Assumes the register map of sdc_regs.svh and a result two cycles after start.
*/
`timescale 1ns/1ps
`include "sdc_regs.svh"
module tb
    import sdc_pkg::*;
;
    localparam logic [8:0] OK = 9'h000, GP = 9'h10D, NP = 9'h10B;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic        done, exc, ifc, accwb;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, mlo, mhi, b, o, e;
    logic [7:0]  vec, ac;
    logic [19:0] l;
    logic [2:0]  slot = 3'h0;
    logic [3:0]  t;
    logic [4:0]  wc;
    logic [63:0] rq [$], x;
    logic [10:0] dq [$];
    logic [15:0] row [12] = '{16'h9B11, 16'h9F11, 16'h9901, 16'h9B04, 16'h9920, 16'h9D24,
                              16'h9131, 16'h9111, 16'h9100, 16'h9330, 16'h1B02, 16'h8201};
    logic [3:0]  gt [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    logic [3:0]  ts [4] = '{4'h1, 4'h3, 4'h9, 4'hB};
    int          mismatches = 0, checked = 0;

    sdc_checker u_dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .DONE_O(done), .EXC_VALID_O(exc), .EXC_VECTOR_O(vec), .IF_CLEAR_O(ifc), .ACC_WB_O(accwb));
    sdc_desc_mem u_mem (.clk_i(clk), .idx_i(slot), .wb_i(accwb), .lo_o(mlo), .hi_o(mhi));

    initial
        forever #10 clk = ~clk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask : bus

    task automatic rdx(input logic [5:0] a, input logic [31:0] v, input logic [31:0] m);
        rq.push_back({m, v & m});
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rdx

    // Descriptor words come from the memory model, as the core would fetch them
    task automatic run(input logic [63:0] d, input logic [31:0] off, input logic [31:0] ctl, input logic [10:0] r);
        slot = slot + 3'h1;
        u_mem.put(slot, d);
        bus(1'b0, 1'b0, 6'h00, 32'h0);
        bus(1'b1, 1'b0, `SDC_A_DESC_LO, mlo);
        bus(1'b1, 1'b0, `SDC_A_DESC_HI, mhi);
        bus(1'b1, 1'b0, `SDC_A_OFFSET, off);
        bus(1'b1, 1'b0, `SDC_A_CTRL, ctl);
        dq.push_back(r);
        bus(1'b1, 1'b0, `SDC_A_CMD, 32'h1);
        // The extra idle edge lets the table take the write-back before the slot moves on
        repeat (4) bus(1'b0, 1'b0, 6'h00, 32'h0);
    endtask : run

    function automatic logic [63:0] mk(input logic [31:0] bs, input logic [19:0] lm, input logic [3:0] gd,
                                       input logic [7:0] acc);
        return {bs[31:24], gd, lm[19:16], acc, bs[23:16], bs[15:0], lm[15:0]};
    endfunction : mk

    always @(posedge clk)
        rd_d <= rd && !rst;

    always @(negedge clk)
    begin
        if (rd_d)
        begin
            x = rq.pop_front();
            chk(rdata & x[63:32], x[31:0]);
        end
        if (done) chk({exc, exc ? vec : 8'h00, ifc, accwb}, dq.pop_front());
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h948C));
        bus(1'b1, 1'b0, 6'h3C, 32'hFFFFFFFF);
        for (int a = 0; a < 64; a += 4) rdx(a[5:0], 32'h0, 32'hFFFFFFFF);
        $display("test reset values done");
        repeat (4)
        begin
            b = $urandom;
            l = 20'($urandom) & 20'hFFFFE;
            t[0] = 1'($urandom);
            e = t[0] ? {l, 12'hFFF} : {12'h0, l};
            run(mk(b, l, {t[0], 3'b000}, 8'h92), e, 32'h0, {OK, 2'b01});
            rdx(`SDC_A_BASE, b, 32'hFFFFFFFF);
            rdx(`SDC_A_LIMIT, e, 32'hFFFFFFFF);
            rdx(`SDC_A_GATE, 32'h9300, 32'hFF00);
            chk(u_mem.tab[slot][40], 1'b1);
            run(mk(b, l, {t[0], 3'b000}, 8'h92), e + 1, 32'h0, {GP, 2'b01});
            run(mk(b, l, 4'h4, 8'h97), {12'h0, l}, 32'h3, {GP, 2'b00});
            run(mk(b, l, 4'h4, 8'h97), {12'h0, l} + 1, 32'h3, {OK, 2'b00});
        end
        run(mk(32'h0, 20'h00FFF, 4'h0, 8'h97), 32'h10000, 32'h3, {GP, 2'b00});
        run(mk(32'h0, 20'h00FFF, 4'h4, 8'h97), 32'h0FFFFFFF, 32'h3, {OK, 2'b00});
        run(mk(32'h0, 20'h00FFF, 4'h4, 8'h97), 32'h10000000, 32'h3, {GP, 2'b00});
        $display("test data limits done");
        foreach (row[i])
        begin
            run(mk(32'h0, 20'hFFFFF, {1'b0, row[i][2], 2'b00}, row[i][15:8]), 32'h0, {29'h0, row[i][6:4]},
                {row[i][1] ? NP : row[i][0] ? GP : OK, 2'b00});
            rdx(`SDC_A_STATUS, {24'h0, row[i][2], 2'b00, row[i][0], row[i][1], ~|row[i][1:0], 2'b10},
                32'h9E);
        end
        $display("test code and data kinds done");
        foreach (gt[i])
            for (int p = 0; p < 2; p++)
            begin
                t = gt[i];
                wc = 5'($urandom);
                o = $urandom;
                b = $urandom;
                ac = {4'h8, t};
                run({o[31:16], ac, 3'b000, wc, b[15:0], o[15:0]}, 32'h0,
                    {16'h0, (t == 4'h5) ? 8'h89 : 8'h9A, 3'b000, p[0], 4'h4}, {OK, t[2:0] == 3'b110, 1'b0});
                rdx(`SDC_A_GOFF, (t == 4'h5) ? 32'h0 : t[3] ? o : {16'h0, o[15:0]}, 32'hFFFFFFFF);
                rdx(`SDC_A_PARAM, (p == 0 || t[1:0] != 2'b00) ? 32'h0 : {27'h0, wc} << (t[3] ? 2 : 1),
                    32'hFFFFFFFF);
                rdx(`SDC_A_GATE, {b[15:0], ac, 3'b000, wc}, 32'hFFFFFFFF);
            end
        run({16'h0, 8'h8C, 40'h0}, 32'h0, 32'h8904, {GP, 2'b00});
        run({16'h0, 8'h85, 40'h0}, 32'h0, 32'h9A04, {GP, 2'b00});
        run({16'h0, 8'h9C, 40'h0}, 32'h0, 32'h9A04, {GP, 2'b00});
        run({16'h0, 8'h0E, 40'h0}, 32'h0, 32'h9A04, {NP, 2'b00});
        $display("test gates done");
        run({16'h0, 8'h82, 40'h0}, 32'h0, 32'h0D, {OK, 2'b00});
        run({16'h0, 8'hE2, 40'h0}, 32'h0, 32'h0D, {OK, 2'b00});
        run({16'h0, 8'h82, 40'h0}, 32'h0, 32'h05, {GP, 2'b00});
        foreach (ts[i])
            for (int g = 0; g < 2; g++)
            begin
                b = $urandom;
                b[31:24] = g ? 8'h00 : b[31:24] | 8'h01;
                l = g ? 20'($urandom) & 20'h0FFFF : 20'($urandom);
                run(mk(b, l, 4'h0, {4'h8, ts[i]}), 32'h0, 32'h0D, {OK, 2'b00});
                rdx(`SDC_A_STATUS, {16'h0, ts[i][3], ts[i][1], 3'b000, 2'b10, g[0], 8'h06}, 32'hC71F);
                rdx(`SDC_A_BASE, b, 32'hFFFFFFFF);
                rdx(`SDC_A_LIMIT, {12'h0, l}, 32'hFFFFFFFF);
            end
        $display("test system descriptors done");
        repeat (3) bus(1'b0, 1'b0, 6'h00, 32'h0);
        wrap_up();
    end
endmodule : tb
